// file: logic/qsc_consts.vh
/*
  Constants for the queued serial command RAM: RAM map, command entry
  field positions, data port layout and default timing counts.
  Assumes it is included by bare name from the design files that need it.
*/
`ifndef QSC_CONSTS_VH
`define QSC_CONSTS_VH

// ==========================================================================
// RAM map
// ==========================================================================
`define RAM_ADDR_W        6
`define RAM_ADDR_MAX      6'h3F
`define TX_BASE           6'h00
`define RX_BASE           6'h10
`define CMD_BASE          6'h20
`define SECTION_END       6'h30
`define ENTRY_W           4
`define ENTRY_COUNT       16

// ==========================================================================
// Data port and command entry layout
// ==========================================================================
`define WORD_W            16
`define CMD_W             8
`define CMD_BYTE_HI       15
`define CMD_BYTE_LO       8
`define CMD_HOLD_BIT      7
`define CMD_WIDTH_BIT     6
`define CMD_POST_BIT      5
`define CMD_LEAD_BIT      4
`define CMD_SEL_HI        3
`define CMD_SEL_LO        0
`define SEL_COUNT         4
`define RESERVED_BYTE     8'h00
`define CMD_RESET         8'h00
`define WORD_RESET        16'h0000

// ==========================================================================
// Transfer sizing and timing
// ==========================================================================
`define BYTE_BITS         5'd8
`define FULL_BITS         5'd16
`define BITS_W            5
`define DLY_W             8
`define SCK_HALF_CYCLES   2

`endif

// file: logic/spi_bit_shifter.v
/*
  Shifts one word out MSB first and in on the serial pins, clock mode 0:
  data changes while the serial clock is low, samples on its rising edge.
  Assumes start is a one-cycle pulse from logic on mclk and miso_sync has
  already passed a two-stage synchroniser.
*/
`timescale 1ns/1ps
`include "qsc_consts.vh"

module spi_bit_shifter #(
  parameter HALF_CYCLES = `SCK_HALF_CYCLES
) (
  input  wire                 mclk,
  input  wire                 rst_b,
  input  wire                 start,
  input  wire [`BITS_W-1:0]   nbits,
  input  wire [`WORD_W-1:0]   tx_word,
  input  wire                 miso_sync,
  output reg                  sck_ff,
  output reg                  mosi_ff,
  output reg  [`WORD_W-1:0]   rx_word_ff,
  output reg                  done_ff
);

  reg  [`WORD_W-1:0] shift_ff;
  reg  [`BITS_W-1:0] bits_left_ff;
  reg  [7:0]         half_cnt_ff;
  reg                active_ff;
  wire [`WORD_W-1:0] aligned;
  wire [`BITS_W-1:0] pad;

  localparam [7:0] HALF_LAST = HALF_CYCLES[7:0] - 8'h01;

  // Left-justify so the first bit out is always bit 15
  assign pad     = `FULL_BITS - nbits;
  assign aligned = tx_word << pad;

  // ========================================================================
  // Bit sequencing
  // ========================================================================
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_ff     <= `WORD_RESET;
      bits_left_ff <= {`BITS_W{1'b0}};
      half_cnt_ff  <= 8'h00;
      active_ff    <= 1'b0;
      sck_ff       <= 1'b0;
      mosi_ff      <= 1'b0;
      rx_word_ff   <= `WORD_RESET;
      done_ff      <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        shift_ff     <= aligned;
        mosi_ff      <= aligned[`WORD_W-1];
        bits_left_ff <= nbits;
        half_cnt_ff  <= HALF_LAST;
        active_ff    <= 1'b1;
        sck_ff       <= 1'b0;
        rx_word_ff   <= `WORD_RESET;
      end else if (active_ff) begin
        if (half_cnt_ff == 8'h00) begin
          half_cnt_ff <= HALF_LAST;
          if (!sck_ff) begin
            sck_ff       <= 1'b1;
            rx_word_ff   <= {rx_word_ff[`WORD_W-2:0], miso_sync};
            bits_left_ff <= bits_left_ff - 5'd1;
          end else begin
            sck_ff <= 1'b0;
            if (bits_left_ff == {`BITS_W{1'b0}}) begin
              active_ff <= 1'b0;
              done_ff   <= 1'b1;
            end else begin
              shift_ff <= {shift_ff[`WORD_W-2:0], 1'b0};
              mosi_ff  <= shift_ff[`WORD_W-2];
            end
          end
        end else begin
          half_cnt_ff <= half_cnt_ff - 8'h01;
        end
      end
    end
  end

endmodule

// file: logic/queued_serial_command_ram.v
/*
  Queue RAM of the serial master with its indirect processor access path
  (address register and data port) and the per-transfer sequencer that
  decodes each command entry.
  Assumes the processor issues one access at a time and waits for cpu_ack;
  chip-select idle level, word width and delay fields come from the
  surrounding controller registers on mclk.
*/
`timescale 1ns/1ps
`include "qsc_consts.vh"

module queued_serial_command_ram #(
  parameter SCK_HALF = `SCK_HALF_CYCLES
) (
  input  wire                   mclk,
  input  wire                   rst_b,
  input  wire                   cpu_data_sel,
  input  wire                   cpu_wr,
  input  wire                   cpu_rd,
  input  wire [`WORD_W-1:0]     cpu_wdata,
  output reg  [`WORD_W-1:0]     cpu_rdata_ff,
  output wire                   cpu_ack,
  input  wire                   select_idle_level,
  input  wire [3:0]             mode_word_width,
  input  wire [`DLY_W-1:0]      post_delay_length,
  input  wire [`DLY_W-1:0]      select_clock_delay,
  input  wire                   queue_start,
  input  wire [`ENTRY_W-1:0]    queue_first_ptr,
  input  wire [`ENTRY_W-1:0]    queue_last_ptr,
  output wire                   queue_busy,
  output reg                    queue_done_ff,
  output reg  [`ENTRY_W-1:0]    done_ptr_ff,
  output reg  [`SEL_COUNT-1:0]  sel_out_ff,
  output wire                   sck,
  output wire                   mosi,
  input  wire                   miso
);

  // ========================================================================
  // State and storage
  // ========================================================================
  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_LEAD  = 5'b00010;
  localparam [4:0] ST_SHIFT = 5'b00100;
  localparam [4:0] ST_POST  = 5'b01000;
  localparam [4:0] ST_NEXT  = 5'b10000;
  localparam [`DLY_W-1:0] HALF_DLY = SCK_HALF[`DLY_W-1:0];

  reg [`WORD_W-1:0]      tx_ff  [0:`ENTRY_COUNT-1];
  reg [`WORD_W-1:0]      rx_ff  [0:`ENTRY_COUNT-1];
  reg [`CMD_W-1:0]       cmd_ff [0:`ENTRY_COUNT-1];
  reg [`RAM_ADDR_W-1:0]  ram_address_reg_ff;
  reg                    rd_pend_ff;
  reg [4:0]              state_ff;
  reg [4:0]              nxt_state;
  reg [`ENTRY_W-1:0]     ptr_ff;
  reg [`DLY_W-1:0]       cnt_ff;
  reg [`DLY_W-1:0]       nxt_cnt;
  reg [`CMD_W-1:0]       cur_cmd_ff;
  reg                    miso_meta_ff;
  reg                    miso_sync_ff;
  reg                    shift_start;
  reg [`SEL_COUNT-1:0]   nxt_sel;
  integer                i;
  integer                j;

  wire                   data_wr;
  wire                   data_rd;
  wire                   addr_wr;
  wire                   addr_rd;
  wire [`ENTRY_W-1:0]    idx;
  wire [`ENTRY_W-1:0]    cur_ptr;
  wire [`CMD_W-1:0]      cur_cmd;
  wire                   shift_done;
  wire [`WORD_W-1:0]     shift_rx;
  wire [`SEL_COUNT-1:0]  idle_sel;
  wire                   last_entry;

  // ========================================================================
  // Helpers
  // ========================================================================
  function in_section;
    input [`RAM_ADDR_W-1:0] a;
    input [`RAM_ADDR_W-1:0] base;
    begin
      in_section = (a[`RAM_ADDR_W-1:`ENTRY_W] == base[`RAM_ADDR_W-1:`ENTRY_W]);
    end
  endfunction

  function [`BITS_W-1:0] xfer_bits;
    input             wide;
    input [3:0]       width;
    begin
      if (!wide)
        xfer_bits = `BYTE_BITS;
      else if (width == 4'h0)
        xfer_bits = `FULL_BITS;
      else
        xfer_bits = {1'b0, width};
    end
  endfunction

  function [`DLY_W-1:0] at_least_one;
    input [`DLY_W-1:0] d;
    begin
      at_least_one = (d == {`DLY_W{1'b0}}) ? 8'h01 : d;
    end
  endfunction

  // ========================================================================
  // Processor access path
  // ========================================================================
  // A request is taken only while no read is waiting for its answer
  assign data_wr  = cpu_wr &  cpu_data_sel & !rd_pend_ff;
  assign data_rd  = cpu_rd &  cpu_data_sel & !rd_pend_ff & !cpu_wr;
  assign addr_wr  = cpu_wr & !cpu_data_sel & !rd_pend_ff;
  assign addr_rd  = cpu_rd & !cpu_data_sel & !rd_pend_ff & !cpu_wr;
  assign cpu_ack  = (cpu_wr & !rd_pend_ff) | rd_pend_ff;
  assign idx      = ram_address_reg_ff[`ENTRY_W-1:0];

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ram_address_reg_ff <= {`RAM_ADDR_W{1'b0}};
      rd_pend_ff         <= 1'b0;
      cpu_rdata_ff       <= `WORD_RESET;
    end else begin
      rd_pend_ff <= data_rd | addr_rd;
      if (addr_wr)
        ram_address_reg_ff <= cpu_wdata[`RAM_ADDR_W-1:0];
      else if ((data_wr | data_rd) && ram_address_reg_ff != `RAM_ADDR_MAX)
        ram_address_reg_ff <= ram_address_reg_ff + 6'h01;
      if (addr_rd) begin
        cpu_rdata_ff <= {{(`WORD_W-`RAM_ADDR_W){1'b0}}, ram_address_reg_ff};
      end else if (data_rd) begin
        if (in_section(ram_address_reg_ff, `TX_BASE))
          cpu_rdata_ff <= tx_ff[idx];
        else if (in_section(ram_address_reg_ff, `RX_BASE))
          cpu_rdata_ff <= rx_ff[idx];
        else if (in_section(ram_address_reg_ff, `CMD_BASE))
          cpu_rdata_ff <= {cmd_ff[idx], `RESERVED_BYTE};
        else
          cpu_rdata_ff <= `WORD_RESET;
      end
    end
  end

  // ========================================================================
  // Queue RAM
  // ========================================================================
  // Command entries have a single writer, the processor
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < `ENTRY_COUNT; i = i + 1) begin
        tx_ff[i]  <= `WORD_RESET;
        cmd_ff[i] <= `CMD_RESET;
      end
    end else if (data_wr) begin
      if (in_section(ram_address_reg_ff, `TX_BASE))
        tx_ff[idx] <= cpu_wdata;
      else if (in_section(ram_address_reg_ff, `CMD_BASE))
        cmd_ff[idx] <= cpu_wdata[`CMD_BYTE_HI:`CMD_BYTE_LO];
    end
  end

  // Received word wins over a processor write to the same entry
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (j = 0; j < `ENTRY_COUNT; j = j + 1)
        rx_ff[j] <= `WORD_RESET;
    end else begin
      if (data_wr && in_section(ram_address_reg_ff, `RX_BASE))
        rx_ff[idx] <= cpu_wdata;
      if (state_ff == ST_SHIFT && shift_done)
        rx_ff[ptr_ff] <= shift_rx;
    end
  end

  // ========================================================================
  // Serial input synchroniser
  // ========================================================================
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      miso_meta_ff <= 1'b0;
      miso_sync_ff <= 1'b0;
    end else begin
      miso_meta_ff <= miso;
      miso_sync_ff <= miso_meta_ff;
    end
  end

  // ========================================================================
  // Transfer sequencer
  // ========================================================================
  assign idle_sel   = {`SEL_COUNT{select_idle_level}};
  assign last_entry = (ptr_ff == queue_last_ptr);
  assign queue_busy = (state_ff != ST_IDLE);
  assign cur_ptr    = (state_ff == ST_IDLE) ? queue_first_ptr : ptr_ff;
  assign cur_cmd    = cmd_ff[cur_ptr];

  always @* begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_sel     = sel_out_ff;
    shift_start = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (queue_start) begin
          nxt_sel   = cur_cmd[`CMD_SEL_HI:`CMD_SEL_LO];
          nxt_state = ST_LEAD;
          if (cur_cmd[`CMD_LEAD_BIT])
            nxt_cnt = at_least_one(select_clock_delay);
          else
            nxt_cnt = HALF_DLY;
        end
      end
      ST_LEAD: begin
        if (cnt_ff == 8'h01) begin
          shift_start = 1'b1;
          nxt_state   = ST_SHIFT;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      ST_SHIFT: begin
        if (shift_done) begin
          if (!cur_cmd_ff[`CMD_HOLD_BIT])
            nxt_sel = idle_sel;
          if (cur_cmd_ff[`CMD_POST_BIT]) begin
            nxt_cnt   = at_least_one(post_delay_length);
            nxt_state = ST_POST;
          end else begin
            nxt_state = ST_NEXT;
          end
        end
      end
      ST_POST: begin
        if (cnt_ff == 8'h01)
          nxt_state = ST_NEXT;
        else
          nxt_cnt = cnt_ff - 8'h01;
      end
      ST_NEXT: begin
        if (last_entry) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_sel   = cmd_ff[ptr_ff + 4'h1][`CMD_SEL_HI:`CMD_SEL_LO];
          nxt_state = ST_LEAD;
          if (cmd_ff[ptr_ff + 4'h1][`CMD_LEAD_BIT])
            nxt_cnt = at_least_one(select_clock_delay);
          else
            nxt_cnt = HALF_DLY;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_sel   = idle_sel;
      end
    endcase
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff      <= ST_IDLE;
      cnt_ff        <= 8'h00;
      ptr_ff        <= {`ENTRY_W{1'b0}};
      cur_cmd_ff    <= `CMD_RESET;
      sel_out_ff    <= {`SEL_COUNT{1'b0}};
      queue_done_ff <= 1'b0;
      done_ptr_ff   <= {`ENTRY_W{1'b0}};
    end else begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      queue_done_ff <= (state_ff == ST_NEXT) && last_entry;
      // Selects follow the idle level when no transfer owns them, unless the last command set its hold bit
      if (state_ff == ST_IDLE && !queue_start && !cur_cmd_ff[`CMD_HOLD_BIT])
        sel_out_ff <= idle_sel;
      else
        sel_out_ff <= nxt_sel;
      if (state_ff == ST_IDLE && queue_start) begin
        ptr_ff     <= queue_first_ptr;
        cur_cmd_ff <= cur_cmd;
      end else if (state_ff == ST_NEXT && !last_entry) begin
        ptr_ff     <= ptr_ff + 4'h1;
        cur_cmd_ff <= cmd_ff[ptr_ff + 4'h1];
      end
      if (state_ff == ST_NEXT)
        done_ptr_ff <= ptr_ff;
    end
  end

  // ========================================================================
  // Bit engine
  // ========================================================================
  spi_bit_shifter #(
    .HALF_CYCLES (SCK_HALF)
  ) u_shifter (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .start      (shift_start),
    .nbits      (xfer_bits(cur_cmd_ff[`CMD_WIDTH_BIT], mode_word_width)),
    .tx_word    (tx_ff[ptr_ff]),
    .miso_sync  (miso_sync_ff),
    .sck_ff     (sck),
    .mosi_ff    (mosi),
    .rx_word_ff (shift_rx),
    .done_ff    (shift_done)
  );

endmodule

// file: sim/qsc_ram_checker.sv
/*
  Port checker for the queued serial command RAM.
  Assumes it is bound into the design top with SCK_HALF handed on.
*/
`timescale 1ns/1ps
`include "qsc_consts.vh"

module qsc_ram_checker #(
  parameter SCK_HALF = 2
) (
  input wire                  mclk,
  input wire                  rst_b,
  input wire                  cpu_wr,
  input wire                  cpu_rd,
  input wire [`WORD_W-1:0]    cpu_rdata_ff,
  input wire                  cpu_ack,
  input wire                  queue_start,
  input wire                  queue_busy,
  input wire                  queue_done_ff,
  input wire [`SEL_COUNT-1:0] sel_out_ff,
  input wire                  sck,
  input wire                  mosi
);
  // =====
  // Helper state
  reg        rd_pend_ff;
  reg  [7:0] hi_cnt_ff;
  wire       nxt_rd_pend = cpu_rd & ~cpu_wr & ~rd_pend_ff;
  wire [7:0] nxt_hi_cnt  = sck ? hi_cnt_ff + 8'h01 : 8'h00;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_ff <= 1'h0;
      hi_cnt_ff  <= 8'h00;
    end else begin
      rd_pend_ff <= nxt_rd_pend;
      hi_cnt_ff  <= nxt_hi_cnt;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // =====
  // Properties
  a_write_ack_now: assert property (cpu_wr && !rd_pend_ff |-> cpu_ack)
    else $error("write not acknowledged in its cycle");
  a_read_one_wait: assert property (nxt_rd_pend |-> !cpu_ack ##1 cpu_ack)
    else $error("read answer not one cycle late");
  a_rdata_on_read: assert property ($changed(cpu_rdata_ff) |-> rd_pend_ff)
    else $error("read data moved without a read");
  a_start_to_busy: assert property (queue_start && !queue_busy |=> queue_busy)
    else $error("queue start not taken");
  a_sck_idle_low: assert property (!queue_busy |-> !sck)
    else $error("serial clock runs outside a queue");
  a_sel_steady: assert property (sck |-> $stable(sel_out_ff))
    else $error("selects moved during a clock high");
  a_mosi_sck_low: assert property ($changed(mosi) |-> !sck)
    else $error("data changed while clock high");
  a_sck_half_len: assert property ($fell(sck) |-> hi_cnt_ff == SCK_HALF)
    else $error("clock high phase wrong length");

  c_read: cover property (rd_pend_ff);
  c_done: cover property (queue_done_ff);
  c_bit: cover property ($fell(sck));
endmodule

// file: sim/spi_peer_model.sv
/*
  Behavioural serial peripheral on the select lines, clock mode 0.
  Assumes sel and idle_level come straight from the design and bench.
*/
`timescale 1ns/1ps

module spi_peer_model (
  input  wire        sck,
  input  wire        mosi,
  input  wire [3:0]  sel,
  input  wire        idle_level,
  input  wire [15:0] reply_word,
  output reg         miso,
  output reg  [15:0] rx_bits,
  output reg  [4:0]  bit_count
);
  reg [15:0] out_sr;

  initial begin
    miso      = 1'h0;
    rx_bits   = 16'h0000;
    bit_count = 5'h00;
    out_sr    = 16'h0000;
  end

  // =====
  // Framing: any select pattern off the idle level opens a frame
  always @(sel or idle_level) begin
    if (sel !== {4{idle_level}}) begin
      bit_count = 5'h00;
      out_sr    = reply_word;
      miso      = reply_word[15];
    end else begin
      // Released line: never leave the last bit standing
      miso = ~miso;
    end
  end

  always @(posedge sck) begin
    rx_bits   = {rx_bits[14:0], mosi};
    bit_count = bit_count + 5'h01;
  end

  always @(negedge sck) begin
    out_sr = {out_sr[14:0], 1'h0};
    miso   = out_sr[15];
  end
endmodule

// file: sim/queued_serial_command_ram_test.sv
/*
  Self-checking bench for the queued serial command RAM.
  Assumes the peer model and checker files are compiled before it.
*/
`timescale 1ns/1ps
`include "qsc_consts.vh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end

module queued_serial_command_ram_test;
  localparam HALF = 4;
  localparam LEAD = 8'h0A;
  localparam POST = 8'h07;
  reg         mclk, rst_b, cpu_data_sel, cpu_wr, cpu_rd, select_idle_level, queue_start;
  reg  [15:0] cpu_wdata, reply_word, d;
  reg  [3:0]  mode_word_width, queue_first_ptr, queue_last_ptr, s;
  reg  [7:0]  post_delay_length, select_clock_delay;
  wire [15:0] cpu_rdata_ff, rx_bits;
  wire [3:0]  done_ptr_ff, sel_out_ff;
  wire [4:0]  bit_count;
  wire        cpu_ack, queue_busy, queue_done_ff, sck, mosi, miso;
  integer     miscompares, check_count, i, t0, l0, t1, l1;

  queued_serial_command_ram #(.SCK_HALF(HALF)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .cpu_data_sel(cpu_data_sel), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata_ff(cpu_rdata_ff), .cpu_ack(cpu_ack),
    .select_idle_level(select_idle_level), .mode_word_width(mode_word_width),
    .post_delay_length(post_delay_length), .select_clock_delay(select_clock_delay),
    .queue_start(queue_start), .queue_first_ptr(queue_first_ptr), .queue_last_ptr(queue_last_ptr),
    .queue_busy(queue_busy), .queue_done_ff(queue_done_ff), .done_ptr_ff(done_ptr_ff),
    .sel_out_ff(sel_out_ff), .sck(sck), .mosi(mosi), .miso(miso));

  spi_peer_model peer_u (
    .sck(sck), .mosi(mosi), .sel(sel_out_ff), .idle_level(select_idle_level),
    .reply_word(reply_word), .miso(miso), .rx_bits(rx_bits), .bit_count(bit_count));

  // =====
  // Bus and queue tasks
  task wr(input reg sl, input reg [15:0] v);
    begin
      @(negedge mclk);
      cpu_data_sel = sl;
      cpu_wdata = v;
      cpu_wr = 1'h1;
      #1;
      `CHK(cpu_ack, 1'h1)
      @(negedge mclk);
      cpu_wr = 1'h0;
    end
  endtask

  // Request held over the answer edge, where it is refused
  task rd(input reg sl);
    begin
      @(negedge mclk);
      cpu_data_sel = sl;
      cpu_rd = 1'h1;
      #1;
      `CHK(cpu_ack, 1'h0)
      @(negedge mclk);
      `CHK(cpu_ack, 1'h1)
      d = cpu_rdata_ff;
      @(negedge mclk);
      cpu_rd = 1'h0;
    end
  endtask

  task run_q(input reg [3:0] e, input reg [3:0] l, output integer tot, output integer ld);
    begin
      @(negedge mclk);
      queue_first_ptr = e;
      queue_last_ptr = l;
      queue_start = 1'h1;
      @(negedge mclk);
      queue_start = 1'h0;
      tot = 1;
      ld = 0;
      while (queue_done_ff !== 1'h1 && tot < 3000) begin
        @(negedge mclk);
        tot = tot + 1;
        if (ld == 0 && sck === 1'h1) begin
          ld = tot;
          s = sel_out_ff;
        end
      end
      `CHK(tot < 3000, 1'b1)
      `CHK(done_ptr_ff, l)
    end
  endtask

  // =====
  // Scenarios
  task t_reset;
    begin
      rd(1'h0);
      `CHK(d[5:0], 6'h00)
      `CHK(sel_out_ff, 4'hF)
    end
  endtask

  task t_ram_path;
    begin
      wr(1'h0, 16'h000E);
      wr(1'h1, 16'h1111);
      wr(1'h1, 16'h2222);
      rd(1'h0);
      `CHK(d[5:0], 6'h10)
      wr(1'h0, 16'h000E);
      rd(1'h1);
      `CHK(d, 16'h1111)
      rd(1'h1);
      `CHK(d, 16'h2222)
      rd(1'h0);
      `CHK(d[5:0], 6'h10)
      wr(1'h0, 16'h003E);
      for (i = 0; i < 3; i++) wr(1'h1, 16'hBEEF);
      rd(1'h0);
      `CHK(d[5:0], 6'h3F)
    end
  endtask

  function [7:0] cmd_of(input integer n);
    case (n)
      0: cmd_of = 8'h0E;
      1: cmd_of = 8'h1E;
      2: cmd_of = 8'h2E;
      3: cmd_of = 8'hC7;
      default: cmd_of = {n[3:0], ~n[3:0]};
    endcase
  endfunction

  task t_cmd_table;
    begin
      wr(1'h0, 16'h0000);
      for (i = 0; i < 4; i++) wr(1'h1, (i == 3) ? 16'h1234 : 16'hA5A5);
      wr(1'h0, 16'h0020);
      for (i = 0; i < 16; i++) wr(1'h1, {cmd_of(i), 8'h00});
      rd(1'h0);
      `CHK(d[5:0], 6'h30)
      wr(1'h0, 16'h0020);
      for (i = 0; i < 16; i++) begin
        rd(1'h1);
        `CHK(d, {cmd_of(i), 8'h00})
      end
    end
  endtask

  task t_queue_plain;
    begin
      run_q(4'h0, 4'h0, t0, l0);
      `CHK(s, 4'hE)
      `CHK(bit_count, 5'h08)
      `CHK(rx_bits[7:0], 8'hA5)
      `CHK(sel_out_ff, 4'hF)
    end
  endtask

  task t_queue_delays;
    begin
      run_q(4'h1, 4'h1, t1, l1);
      `CHK(l1 - l0, LEAD - HALF)
      run_q(4'h2, 4'h2, t1, l1);
      `CHK(t1 - t0, POST)
      `CHK(l1, l0)
      // Three entries back to back: entry 1 adds its lead time and entry 2 its post time
      run_q(4'h0, 4'h2, t1, l1);
      `CHK(t1, 3 * t0 + LEAD - HALF + POST - 2)
      `CHK(l1, l0)
      `CHK(bit_count, 5'h08)
      `CHK(sel_out_ff, 4'hF)
    end
  endtask

  task t_queue_wide_hold;
    begin
      run_q(4'h3, 4'h3, t1, l1);
      `CHK(bit_count, 5'h10)
      `CHK(rx_bits, 16'h1234)
      `CHK(sel_out_ff, 4'h7)
      wr(1'h0, 16'h0013);
      rd(1'h1);
      `CHK(d, 16'hC3A5)
      wr(1'h0, 16'h0023);
      rd(1'h1);
      `CHK(d, 16'hC700)
    end
  endtask

  task t_idle_low;
    begin
      select_idle_level = 1'h0;
      run_q(4'h0, 4'h0, t1, l1);
      `CHK(sel_out_ff, 4'h0)
      mode_word_width = 4'hC;
      run_q(4'h3, 4'h3, t1, l1);
      `CHK(bit_count, 5'h0C)
      `CHK(rx_bits[11:0], 12'h234)
    end
  endtask

  task end_of_test;
    begin
      $display("compares %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // =====
  // Clock, watchdog and main sequence
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #3000000;
    miscompares++;
    end_of_test;
  end

  initial begin
    miscompares = 0;
    check_count = 0;
    rst_b = 1'h0;
    {cpu_data_sel, cpu_wr, cpu_rd, queue_start} = 4'h0;
    cpu_wdata = 16'h0000;
    select_idle_level = 1'h1;
    mode_word_width = 4'h0;
    post_delay_length = POST;
    select_clock_delay = LEAD;
    {queue_first_ptr, queue_last_ptr} = 8'h00;
    reply_word = 16'hC3A5;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'h1;
    t_reset;
    t_ram_path;
    t_cmd_table;
    t_queue_plain;
    t_queue_delays;
    t_queue_wide_hold;
    t_idle_low;
    end_of_test;
  end
endmodule

bind queued_serial_command_ram qsc_ram_checker #(.SCK_HALF(SCK_HALF)) chk_u (
  .mclk(mclk), .rst_b(rst_b), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata_ff(cpu_rdata_ff),
  .cpu_ack(cpu_ack), .queue_start(queue_start), .queue_busy(queue_busy),
  .queue_done_ff(queue_done_ff), .sel_out_ff(sel_out_ff), .sck(sck), .mosi(mosi));
